// file: logic/addr_region_decode.sv
`timescale 1ns/1ps
module addr_region_decode
#(
   parameter int ROM_BYTES = core_map_pkg::ROM_BYTES_DEF,
   parameter int LS_BYTES  = core_map_pkg::LS_BYTES_DEF
)
(
   // Address under decode
   input  wire logic [15:0]          addr_i,
   input  wire logic                 wide_i,
   // Decode results
   output core_map_pkg::region_s     region_o,
   output logic                      align_err_o
);
   import core_map_pkg::*;

   localparam logic [15:0] LS_BASE = 16'(int'(DISP_BASE) - LS_BYTES);

   function automatic logic in_range(input logic [15:0] a,
                                     input logic [15:0] lo,
                                     input logic [15:0] hi);
      in_range = (a >= lo) && (a <= hi);
   endfunction

   wire logic rom_hit    = int'(addr_i) < ROM_BYTES;
   wire logic periph_hit = addr_i >= PERIPH_BASE;
   wire logic ls_hit     = in_range(addr_i, LS_BASE, DISP_BASE - 16'h1);
   wire logic disp_hit   = in_range(addr_i, DISP_BASE, DISP_LAST);
   wire logic hs_hit     = in_range(addr_i, HS_BASE, HS_LAST);

   // Program memory sub-regions, data regions and the unmapped flag
   assign region_o.rom      = rom_hit;
   assign region_o.vec      = in_range(addr_i, RST_VEC_ADDR, VEC_LAST);
   assign region_o.tcall    = in_range(addr_i, TCALL_BASE, TCALL_LAST);
   assign region_o.ls_ram   = ls_hit;
   assign region_o.disp     = disp_hit;
   assign region_o.hs_ram   = hs_hit;
   assign region_o.periph   = periph_hit;
   assign region_o.unmapped = !(rom_hit || ls_hit || disp_hit || hs_hit
                                || periph_hit);

   // Word access to the register window needs an even address
   assign align_err_o = wide_i && periph_hit && addr_i[0];

endmodule

// file: logic/core_map_pkg.sv
package core_map_pkg;

   // Address map
   localparam logic [15:0] RST_VEC_ADDR  = 16'h0000;
   localparam logic [15:0] VEC_LAST      = 16'h002B;
   localparam logic [15:0] VEC_IRQ_BASE  = 16'h0004;
   localparam logic [15:0] TCALL_BASE    = 16'h0040;
   localparam logic [15:0] TCALL_LAST    = 16'h007F;
   localparam logic [15:0] DISP_BASE     = 16'hF8C0;
   localparam logic [15:0] DISP_LAST     = 16'hFAFF;
   localparam logic [15:0] HS_BASE       = 16'hFB00;
   localparam logic [15:0] HS_LAST       = 16'hFEFF;
   localparam logic [15:0] PERIPH_BASE   = 16'hFF00;
   localparam int          ROM_BYTES_DEF = 61440;
   localparam int          LS_BYTES_DEF  = 1216;
   localparam int          IRQ_SRCS      = 21;
   localparam int          NUM_GR        = 8;

   // Status flag layout
   localparam int          PSW_IE        = 7;
   localparam int          PSW_Z         = 6;
   localparam int          PSW_AC        = 4;
   localparam int          PSW_ONE       = 1;
   localparam int          PSW_CY        = 0;
   localparam logic [7:0]  PSW_RESET     = 8'h02;
   localparam logic [7:0]  PSW_WR_MASK   = 8'hD1;
   localparam logic [15:0] SP_RESET      = 16'h0000;

   typedef enum logic [3:0] {
      CMD_NOP      = 4'h0,
      CMD_ADV      = 4'h1,
      CMD_JMP_IMM  = 4'h2,
      CMD_JMP_PAIR = 4'h3,
      CMD_TCALL    = 4'h4,
      CMD_PUSH_PSW = 4'h5,
      CMD_POP_PSW  = 4'h6,
      CMD_INTERRUPT_RETURN_INSTRUCTION     = 4'h7,
      CMD_DI       = 4'h8,
      CMD_EI       = 4'h9,
      CMD_LD_SP    = 4'hA,
      CMD_ALU      = 4'hB,
      CMD_ROT      = 4'hC,
      CMD_BIT_CY   = 4'hD
   } cmd_e;

   typedef struct packed {
      logic rom;
      logic vec;
      logic tcall;
      logic ls_ram;
      logic disp;
      logic hs_ram;
      logic periph;
      logic unmapped;
   } region_s;

   typedef struct packed {
      logic [7:0] a;
      logic [7:0] b;
      logic       sub;
   } alu_in_s;

endpackage

// file: logic/cpu_core_regs_and_memory_map.sv
`timescale 1ns/1ps
module cpu_core_regs_and_memory_map
#(
   parameter int ROM_BYTES = core_map_pkg::ROM_BYTES_DEF,
   parameter int LS_BYTES  = core_map_pkg::LS_BYTES_DEF
)
(
   // Clock and reset
   input  wire logic                        SYS_CLK_I,
   input  wire logic                        RST_N_I,
   // Command port
   input  wire logic                        CMD_VALID_I,
   input  wire core_map_pkg::cmd_e          CMD_I,
   output logic                             CMD_READY_O,
   input  wire logic [15:0]                 IMM_I,
   input  wire logic [2:0]                  INSTR_LEN_I,
   input  wire core_map_pkg::alu_in_s       ALU_I,
   output logic [7:0]                       ALU_RESULT_O,
   // Data access decode
   input  wire logic [15:0]                 EXT_ADDR_I,
   input  wire logic                        EXT_WIDE_I,
   // Memory port
   output logic [15:0]                      MEM_ADDR_O,
   output logic                             MEM_RD_O,
   output logic                             MEM_WR_O,
   output logic [7:0]                       MEM_WDATA_O,
   input  wire logic [7:0]                  MEM_RDATA_I,
   output core_map_pkg::region_s            MEM_REGION_O,
   output logic                             ALIGN_ERR_O,
   // Interrupts
   input  wire logic [20:0]                 IRQ_REQ_I,
   input  wire logic [20:0]                 IRQ_MASK_I,
   output logic                             IRQ_ACK_O,
   output logic [4:0]                       IRQ_ACK_ID_O,
   // General registers
   input  wire logic                        GR_WE_I,
   input  wire logic                        GR_WIDE_I,
   input  wire logic [2:0]                  GR_SEL_I,
   input  wire logic [15:0]                 GR_WDATA_I,
   output logic [15:0]                      GR_RDATA_O,
   // Architectural state
   output logic [15:0]                      INSTR_PTR_O,
   output logic [7:0]                       STATUS_FLAGS_O,
   output logic [15:0]                      STACK_PTR_O,
   output logic                             STACK_UNINIT_O,
   output logic                             STACK_RANGE_ERR_O
);
   import core_map_pkg::*;

   typedef enum logic [10:0] {
      ST_RST_LO   = 11'h001,
      ST_RST_HI   = 11'h002,
      ST_IDLE     = 11'h004,
      ST_LD_LO    = 11'h008,
      ST_LD_HI    = 11'h010,
      ST_PUSH_PSW = 11'h020,
      ST_PUSH_PCH = 11'h040,
      ST_PUSH_PCL = 11'h080,
      ST_POP_PCL  = 11'h100,
      ST_POP_PCH  = 11'h200,
      ST_POP_PSW  = 11'h400
   } state_e;

   state_e      state_r, state_nxt;
   logic [15:0] pc_r, pc_nxt;
   logic [7:0]  psw_r, psw_nxt;
   logic [15:0] sp_r, sp_nxt;
   logic [15:0] ptr_r, ptr_nxt;
   logic        irq_seq_r, irq_seq_nxt;
   logic        interrupt_return_instruction_r, interrupt_return_instruction_nxt;
   logic        sp_loaded_r;
   logic        uninit_r;
   logic [4:0]  ack_id_r;
   logic [7:0]  alu_res_r;
   logic [15:0] gr_rdata_r;
   logic [7:0]  gr_r [NUM_GR];

   function automatic logic [4:0] first_set(input logic [20:0] v);
      first_set = 5'h00;
      for (int i = IRQ_SRCS - 1; i >= 0; i--)
         if (v[i])
            first_set = 5'(i);
   endfunction

   // Command and interrupt qualification
   wire logic        cmd_take   = CMD_VALID_I && (state_r == ST_IDLE);
   wire logic [20:0] irq_live   = IRQ_REQ_I & ~IRQ_MASK_I;
   wire logic        irq_take   = (state_r == ST_IDLE) && !CMD_VALID_I
                                  && psw_r[PSW_IE] && (|irq_live);
   wire logic [4:0]  irq_idx    = first_set(irq_live);
   wire logic [15:0] irq_vec    = VEC_IRQ_BASE + {10'h000, irq_idx, 1'b0};
   wire logic [15:0] tcall_vec  = TCALL_BASE + {10'h000, IMM_I[4:0], 1'b0};
   wire logic [15:0] sp_dec     = sp_r - 16'h0001;
   wire logic [15:0] acc_pair   = {gr_r[1], gr_r[0]};
   wire logic        stack_op   = (state_r == ST_PUSH_PSW)
                                  || (state_r == ST_POP_PCL)
                                  || (state_r == ST_POP_PSW && !interrupt_return_instruction_r);

   // Flag arithmetic
   wire logic [8:0]  sum9       = ALU_I.sub ? {1'b0, ALU_I.a} - {1'b0, ALU_I.b}
                                            : {1'b0, ALU_I.a} + {1'b0, ALU_I.b};
   wire logic [4:0]  half5      = ALU_I.sub
                                  ? {1'b0, ALU_I.a[3:0]} - {1'b0, ALU_I.b[3:0]}
                                  : {1'b0, ALU_I.a[3:0]} + {1'b0, ALU_I.b[3:0]};
   wire logic [7:0]  rot_res    = ALU_I.sub ? {ALU_I.a[0], ALU_I.a[7:1]}
                                            : {ALU_I.a[6:0], ALU_I.a[7]};
   wire logic        rot_out    = ALU_I.sub ? ALU_I.a[0] : ALU_I.a[7];

   // Memory address and strobes
   assign MEM_RD_O    = (state_r == ST_RST_LO) || (state_r == ST_RST_HI)
                        || (state_r == ST_LD_LO) || (state_r == ST_LD_HI)
                        || (state_r == ST_POP_PCL) || (state_r == ST_POP_PCH)
                        || (state_r == ST_POP_PSW);
   assign MEM_WR_O    = (state_r == ST_PUSH_PSW) || (state_r == ST_PUSH_PCH)
                        || (state_r == ST_PUSH_PCL);
   assign MEM_ADDR_O  = (state_r == ST_RST_LO) ? RST_VEC_ADDR :
                        (state_r == ST_RST_HI) ? RST_VEC_ADDR + 16'h0001 :
                        (state_r == ST_LD_LO)  ? ptr_r :
                        (state_r == ST_LD_HI)  ? (ptr_r | 16'h0001) :
                        MEM_WR_O               ? sp_dec :
                        MEM_RD_O               ? sp_r : EXT_ADDR_I;
   assign MEM_WDATA_O = (state_r == ST_PUSH_PSW) ? psw_r :
                        (state_r == ST_PUSH_PCH) ? pc_r[15:8] : pc_r[7:0];

   addr_region_decode
   #(
      .ROM_BYTES (ROM_BYTES),
      .LS_BYTES  (LS_BYTES)
   )
   u_decode
   (
      .addr_i      (MEM_ADDR_O),
      .wide_i      (EXT_WIDE_I && state_r == ST_IDLE),
      .region_o    (MEM_REGION_O),
      .align_err_o (ALIGN_ERR_O)
   );

   // Sequencer
   always_comb
   begin
      state_nxt   = state_r;
      pc_nxt      = pc_r;
      psw_nxt     = psw_r;
      sp_nxt      = sp_r;
      ptr_nxt     = ptr_r;
      irq_seq_nxt = irq_seq_r;
      interrupt_return_instruction_nxt    = interrupt_return_instruction_r;
      case (state_r)
         ST_RST_LO:
         begin
            pc_nxt    = {pc_r[15:8], MEM_RDATA_I};
            state_nxt = ST_RST_HI;
         end
         ST_RST_HI:
         begin
            pc_nxt    = {MEM_RDATA_I, pc_r[7:0]};
            state_nxt = ST_IDLE;
         end
         ST_IDLE:
         begin
            if (cmd_take)
            begin
               case (CMD_I)
                  CMD_ADV:      pc_nxt = pc_r + {13'h0000, INSTR_LEN_I};
                  CMD_JMP_IMM:  pc_nxt = IMM_I;
                  CMD_JMP_PAIR: pc_nxt = acc_pair;
                  CMD_TCALL:
                  begin
                     ptr_nxt   = tcall_vec;
                     state_nxt = ST_LD_LO;
                  end
                  CMD_PUSH_PSW:
                  begin
                     irq_seq_nxt = 1'b0;
                     state_nxt   = ST_PUSH_PSW;
                  end
                  CMD_POP_PSW:
                  begin
                     interrupt_return_instruction_nxt  = 1'b0;
                     state_nxt = ST_POP_PSW;
                  end
                  CMD_INTERRUPT_RETURN_INSTRUCTION:
                  begin
                     interrupt_return_instruction_nxt  = 1'b1;
                     state_nxt = ST_POP_PCL;
                  end
                  CMD_DI:       psw_nxt[PSW_IE] = 1'b0;
                  CMD_EI:       psw_nxt[PSW_IE] = 1'b1;
                  CMD_LD_SP:    sp_nxt = IMM_I;
                  CMD_ALU:
                  begin
                     psw_nxt[PSW_Z]  = (sum9[7:0] == 8'h00);
                     psw_nxt[PSW_AC] = half5[4];
                     psw_nxt[PSW_CY] = sum9[8];
                  end
                  CMD_ROT:      psw_nxt[PSW_CY] = rot_out;
                  CMD_BIT_CY:   psw_nxt[PSW_CY] = ALU_I.b[0];
                  default:      pc_nxt = pc_r;
               endcase
            end
            else if (irq_take)
            begin
               ptr_nxt     = irq_vec;
               irq_seq_nxt = 1'b1;
               state_nxt   = ST_PUSH_PSW;
            end
         end
         ST_LD_LO:
         begin
            pc_nxt    = {pc_r[15:8], MEM_RDATA_I};
            state_nxt = ST_LD_HI;
         end
         ST_LD_HI:
         begin
            pc_nxt    = {MEM_RDATA_I, pc_r[7:0]};
            state_nxt = ST_IDLE;
         end
         ST_PUSH_PSW:
         begin
            sp_nxt = sp_dec;
            if (irq_seq_r)
            begin
               psw_nxt[PSW_IE] = 1'b0;
               state_nxt       = ST_PUSH_PCH;
            end
            else
               state_nxt = ST_IDLE;
         end
         ST_PUSH_PCH:
         begin
            sp_nxt    = sp_dec;
            state_nxt = ST_PUSH_PCL;
         end
         ST_PUSH_PCL:
         begin
            sp_nxt    = sp_dec;
            state_nxt = ST_LD_LO;
         end
         ST_POP_PCL:
         begin
            pc_nxt    = {pc_r[15:8], MEM_RDATA_I};
            sp_nxt    = sp_r + 16'h0001;
            state_nxt = ST_POP_PCH;
         end
         ST_POP_PCH:
         begin
            pc_nxt    = {MEM_RDATA_I, pc_r[7:0]};
            sp_nxt    = sp_r + 16'h0001;
            state_nxt = ST_POP_PSW;
         end
         ST_POP_PSW:
         begin
            psw_nxt   = (MEM_RDATA_I & PSW_WR_MASK) | PSW_RESET;
            sp_nxt    = sp_r + 16'h0001;
            state_nxt = ST_IDLE;
         end
         default:
            state_nxt = ST_IDLE;
      endcase
   end

   always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         state_r   <= ST_RST_LO;
         pc_r      <= RST_VEC_ADDR;
         psw_r     <= PSW_RESET;
         sp_r      <= SP_RESET;
         ptr_r     <= RST_VEC_ADDR;
         irq_seq_r <= 1'b0;
         interrupt_return_instruction_r    <= 1'b0;
      end
      else
      begin
         state_r   <= state_nxt;
         pc_r      <= pc_nxt;
         psw_r     <= psw_nxt;
         sp_r      <= sp_nxt;
         ptr_r     <= ptr_nxt;
         irq_seq_r <= irq_seq_nxt;
         interrupt_return_instruction_r    <= interrupt_return_instruction_nxt;
      end
   end

   // Stack load tracking and result capture
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         sp_loaded_r <= 1'b0;
         uninit_r    <= 1'b0;
         ack_id_r    <= 5'h00;
         alu_res_r   <= 8'h00;
         gr_rdata_r  <= 16'h0000;
      end
      else
      begin
         sp_loaded_r <= sp_loaded_r || (cmd_take && CMD_I == CMD_LD_SP);
         uninit_r    <= uninit_r || (stack_op && !sp_loaded_r);
         if (irq_take)
            ack_id_r <= irq_idx;
         if (cmd_take && CMD_I == CMD_ALU)
            alu_res_r <= sum9[7:0];
         else if (cmd_take && CMD_I == CMD_ROT)
            alu_res_r <= rot_res;
         gr_rdata_r  <= GR_WIDE_I
                        ? {gr_r[{GR_SEL_I[1:0], 1'b1}], gr_r[{GR_SEL_I[1:0], 1'b0}]}
                        : {8'h00, gr_r[GR_SEL_I]};
      end
   end

   // General registers, contents undefined after reset
   for (genvar g = 0; g < NUM_GR; g++)
   begin : g_gr
      wire logic byte_we = GR_WE_I && !GR_WIDE_I && GR_SEL_I == 3'(g);
      wire logic pair_we = GR_WE_I && GR_WIDE_I
                           && GR_SEL_I[1:0] == 2'(g / 2);
      always_ff @(posedge SYS_CLK_I)
      begin
         if (byte_we)
            gr_r[g] <= GR_WDATA_I[7:0];
         else if (pair_we)
            gr_r[g] <= (g % 2 == 1) ? GR_WDATA_I[15:8] : GR_WDATA_I[7:0];
      end
   end

   assign CMD_READY_O       = state_r == ST_IDLE;
   assign ALU_RESULT_O      = alu_res_r;
   assign IRQ_ACK_O         = (state_r == ST_PUSH_PSW) && irq_seq_r;
   assign IRQ_ACK_ID_O      = ack_id_r;
   assign GR_RDATA_O        = gr_rdata_r;
   assign INSTR_PTR_O       = pc_r;
   assign STATUS_FLAGS_O    = psw_r;
   assign STACK_PTR_O       = sp_r;
   assign STACK_UNINIT_O    = uninit_r;
   assign STACK_RANGE_ERR_O = sp_loaded_r
                              && !(sp_r > HS_BASE && sp_r <= HS_LAST + 16'h1);

   // Checks
   default clocking cb @(posedge SYS_CLK_I); endclocking
   default disable iff (!RST_N_I);

   sequence s_push3;
      MEM_WR_O ##1 MEM_WR_O ##1 MEM_WR_O;
   endsequence
   sequence s_vec_load(logic [15:0] v);
      MEM_RD_O && MEM_ADDR_O == v ##1 MEM_RD_O && MEM_ADDR_O == (v | 16'h1);
   endsequence

   a_reset_vec_fetch: assert property (state_r == ST_RST_LO |->
      s_vec_load(RST_VEC_ADDR) ##1 state_r == ST_IDLE)
      else $error("reset vector not fetched from bytes 0 and 1");
   a_psw_fixed_bits: assert property ((psw_r & ~PSW_WR_MASK) == PSW_RESET)
      else $error("status flag fixed bits wrong");
   a_irq_refused: assert property (state_r == ST_IDLE && !CMD_VALID_I
      && !psw_r[PSW_IE] |=> state_r != ST_PUSH_PSW)
      else $error("request taken while interrupts disabled");
   a_irq_sequence: assert property (irq_take |=> IRQ_ACK_O
      ##0 s_push3 ##1 MEM_RD_O && MEM_ADDR_O == $past(irq_vec, 4)
      ##1 MEM_RD_O && MEM_ADDR_O == ($past(irq_vec, 5) | 16'h1))
      else $error("interrupt push or vector fetch wrong");
   a_ack_clears_ie: assert property (IRQ_ACK_O |=> !psw_r[PSW_IE])
      else $error("enable flag not cleared by acknowledge");
   a_push_predec: assert property (MEM_WR_O |-> MEM_ADDR_O == sp_r - 16'h1
      ##1 sp_r == $past(sp_r) - 16'h1)
      else $error("stack write not pre-decremented");
   a_pop_postinc: assert property (MEM_RD_O && state_r inside {ST_POP_PCL,
      ST_POP_PCH, ST_POP_PSW} |-> MEM_ADDR_O == sp_r
      ##1 sp_r == $past(sp_r) + 16'h1)
      else $error("stack read not post-incremented");
   a_pc_advance: assert property (cmd_take && CMD_I == CMD_ADV |=>
      pc_r == $past(pc_r) + {13'h0000, $past(INSTR_LEN_I)})
      else $error("pointer did not advance by length");
   a_zero_flag: assert property (cmd_take && CMD_I == CMD_ALU |=>
      psw_r[PSW_Z] == (ALU_RESULT_O == 8'h00))
      else $error("zero flag disagrees with result");
   a_periph_window: assert property (MEM_REGION_O.periph
      == (MEM_ADDR_O[15:8] == 8'hFF))
      else $error("peripheral window decode wrong");

endmodule

// file: verif/cpu_core_regs_and_memory_map_tb_top.sv
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fails++; \
   $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module cpu_core_regs_and_memory_map_tb_top;
   import core_map_pkg::*;
   logic        clk, rst_n, valid, ready, ext_wide, rd, wr, ack;
   logic        align, gr_we, gr_wide, uninit, rng_err;
   cmd_e        cmd_v;
   alu_in_s     alu;
   region_s     region;
   logic [2:0]  len, gr_sel;
   logic [4:0]  ack_id;
   logic [7:0]  res, wdata, rdata, status_flags_register;
   logic [15:0] imm_v, ext_addr, addr, gr_wdata, gr_rdata, pc, sp;
   logic [20:0] irq_req, irq_mask;
   int          fails, num_checks, n;

   cpu_core_regs_and_memory_map cpu_core_regs_and_memory_map_inst (
      .SYS_CLK_I(clk), .RST_N_I(rst_n), .CMD_VALID_I(valid), .CMD_I(cmd_v),
      .CMD_READY_O(ready), .IMM_I(imm_v), .INSTR_LEN_I(len), .ALU_I(alu),
      .ALU_RESULT_O(res), .EXT_ADDR_I(ext_addr), .EXT_WIDE_I(ext_wide),
      .MEM_ADDR_O(addr), .MEM_RD_O(rd), .MEM_WR_O(wr), .MEM_WDATA_O(wdata),
      .MEM_RDATA_I(rdata), .MEM_REGION_O(region), .ALIGN_ERR_O(align),
      .IRQ_REQ_I(irq_req), .IRQ_MASK_I(irq_mask), .IRQ_ACK_O(ack),
      .IRQ_ACK_ID_O(ack_id), .GR_WE_I(gr_we), .GR_WIDE_I(gr_wide),
      .GR_SEL_I(gr_sel), .GR_WDATA_I(gr_wdata), .GR_RDATA_O(gr_rdata),
      .INSTR_PTR_O(pc), .STATUS_FLAGS_O(status_flags_register), .STACK_PTR_O(sp),
      .STACK_UNINIT_O(uninit),
      .STACK_RANGE_ERR_O(rng_err));

   mem_model mem_model_inst (.clk_i(clk), .addr_i(addr), .rd_i(rd),
      .wr_i(wr), .wdata_i(wdata), .rdata_o(rdata));

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task tick;
      @(posedge clk);
      #1;
   endtask

   task wait_rdy;
      n = 0;
      while (!ready && n < 50)
      begin
         tick;
         n++;
      end
      if (n >= 50) fails++;
   endtask

   // Hold the command until the edge that takes it, then wait for idle
   task automatic cmd(input cmd_e c, input logic [15:0] imm);
      tick;
      valid = 1'b1;
      cmd_v = c;
      imm_v = imm;
      wait_rdy;
      tick;
      valid = 1'b0;
      wait_rdy;
   endtask

   task automatic dec(input logic [15:0] a, input logic w);
      ext_addr = a;
      ext_wide = w;
      #1;
   endtask

   task test_done;
      if (fails == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   initial
   begin
      #200000;
      fails++;
      test_done;
   end

   initial
   begin
      {rst_n, valid, ext_wide, gr_we, gr_wide} = '0;
      cmd_v = CMD_NOP;
      {imm_v, ext_addr, gr_wdata, irq_req, irq_mask, len, gr_sel} = '0;
      alu = '0;
      fails = 0;
      num_checks = 0;
      mem_model_inst.mem[16'h0000] = 8'h34;
      mem_model_inst.mem[16'h0001] = 8'h12;
      mem_model_inst.mem[16'h0044] = 8'h78;
      mem_model_inst.mem[16'h0045] = 8'h56;
      mem_model_inst.mem[16'h000A] = 8'h00;
      mem_model_inst.mem[16'h000B] = 8'h20;
      repeat (5) @(posedge clk);
      #1;
      rst_n = 1'b1;
      wait_rdy;
      `CHK(pc, 16'h1234)
      `CHK(status_flags_register, 8'h02)
      len = 3'h3;
      cmd(CMD_ADV, 16'h0000);
      `CHK(pc, 16'h1237)
      cmd(CMD_JMP_IMM, 16'h0100);
      `CHK(pc, 16'h0100)
      cmd(CMD_LD_SP, 16'hFE00);
      `CHK(sp, 16'hFE00)
      cmd(CMD_LD_SP, 16'h0100);
      `CHK(rng_err, 1'b1)
      cmd(CMD_LD_SP, 16'hFE00);
      `CHK({uninit, rng_err, sp}, 18'h0FE00)
      cmd(CMD_PUSH_PSW, 16'h0000);
      `CHK(sp, 16'hFDFF)
      `CHK(mem_model_inst.mem[16'hFDFF], 8'h02)
      cmd(CMD_EI, 16'h0000);
      `CHK(status_flags_register, 8'h82)
      cmd(CMD_POP_PSW, 16'h0000);
      `CHK(status_flags_register, 8'h02)
      `CHK(sp, 16'hFE00)
      alu = '{a: 8'h0F, b: 8'h01, sub: 1'b0};
      cmd(CMD_ALU, 16'h0000);
      `CHK({res, status_flags_register}, 16'h1012)
      alu = '{a: 8'hFF, b: 8'h01, sub: 1'b0};
      cmd(CMD_ALU, 16'h0000);
      `CHK({res, status_flags_register}, 16'h0053)
      alu = '{a: 8'h10, b: 8'h01, sub: 1'b1};
      cmd(CMD_ALU, 16'h0000);
      `CHK({res, status_flags_register}, 16'h0F12)
      alu = '{a: 8'h81, b: 8'h00, sub: 1'b0};
      cmd(CMD_ROT, 16'h0000);
      `CHK({res, status_flags_register}, 16'h0313)
      alu = '{a: 8'h02, b: 8'h00, sub: 1'b1};
      cmd(CMD_ROT, 16'h0000);
      `CHK({res, status_flags_register}, 16'h0112)
      alu = '{a: 8'h00, b: 8'h01, sub: 1'b0};
      cmd(CMD_BIT_CY, 16'h0000);
      `CHK(status_flags_register, 8'h13)
      alu = '{a: 8'h00, b: 8'h00, sub: 1'b0};
      cmd(CMD_BIT_CY, 16'h0000);
      `CHK(status_flags_register, 8'h12)
      cmd(CMD_TCALL, 16'h0002);
      `CHK(pc, 16'h5678)
      // Source 1 is masked, source 3 must win once enabled
      irq_req = 21'h00000A;
      irq_mask = 21'h000002;
      repeat (3)
      begin
         tick;
         `CHK(ack, 1'b0)
      end
      cmd(CMD_EI, 16'h0000);
      n = 0;
      while (ack !== 1'b1 && n < 10)
      begin
         tick;
         n++;
      end
      `CHK(ack, 1'b1)
      irq_req = '0;
      wait_rdy;
      `CHK(ack_id, 5'h03)
      `CHK(pc, 16'h2000)
      `CHK(status_flags_register, 8'h12)
      `CHK(sp, 16'hFDFD)
      `CHK(mem_model_inst.mem[16'hFDFF], 8'h92)
      `CHK(mem_model_inst.mem[16'hFDFD], 8'h78)
      cmd(CMD_INTERRUPT_RETURN_INSTRUCTION, 16'h0000);
      `CHK({pc, status_flags_register}, 24'h567892)
      `CHK(sp, 16'hFE00)
      cmd(CMD_DI, 16'h0000);
      `CHK(status_flags_register, 8'h12)
      dec(16'hFF01, 1'b1);
      `CHK({align, region.periph}, 2'h3)
      dec(16'hFF02, 1'b1);
      `CHK(align, 1'b0)
      dec(16'hF900, 1'b0);
      `CHK(region.disp, 1'b1)
      dec(16'h0002, 1'b0);
      `CHK(region.vec, 1'b1)
      dec(16'h0050, 1'b0);
      `CHK(region.tcall, 1'b1)
      dec(16'hFC00, 1'b0);
      `CHK(region.hs_ram, 1'b1)
      gr_we = 1'b1;
      gr_wide = 1'b1;
      gr_wdata = 16'hABCD;
      tick;
      gr_we = 1'b0;
      gr_wide = 1'b0;
      gr_sel = 3'h1;
      tick;
      `CHK(gr_rdata[7:0], 8'hAB)
      gr_sel = 3'h0;
      tick;
      `CHK(gr_rdata[7:0], 8'hCD)
      cmd(CMD_JMP_PAIR, 16'h0000);
      `CHK(pc, 16'hABCD)
      // Second reset, then a stack access before any pointer load
      rst_n = 1'b0;
      tick;
      rst_n = 1'b1;
      wait_rdy;
      `CHK({pc, status_flags_register}, 24'h123402)
      `CHK({uninit, rng_err}, 2'h0)
      cmd(CMD_PUSH_PSW, 16'h0000);
      `CHK(uninit, 1'b1)
      test_done;
   end
endmodule

// file: verif/mem_model.sv
`timescale 1ns/1ps
module mem_model
(
   // Memory side
   input  wire logic        clk_i,
   input  wire logic [15:0] addr_i,
   input  wire logic        rd_i,
   input  wire logic        wr_i,
   input  wire logic [7:0]  wdata_i,
   output logic      [7:0]  rdata_o
);
   logic [7:0] mem [0:65535];

   // Inverted byte while not read, so a stale value never passes
   assign rdata_o = rd_i ? mem[addr_i] : ~mem[addr_i];

   always @(posedge clk_i)
   begin
      if (wr_i)
      begin
         mem[addr_i] <= wdata_i;
      end
   end
endmodule
